// ### rtl/ues_pkg.sv
package ues_pkg;
   localparam logic [7:0] UES_OFF_ERR_FLAGS = 8'h00;
   localparam logic [7:0] UES_OFF_ERR_ENABLES = 8'h04;
   localparam logic [7:0] UES_OFF_XFER_STATUS = 8'h08;
   localparam logic [7:0] UES_OFF_CONTROL = 8'h0C;
   localparam logic [7:0] UES_OFF_INT_CTRL = 8'h10;
   localparam int UES_ERR_PID = 0;
   localparam int UES_ERR_CRC5_EOF = 1;
   localparam int UES_ERR_CRC16 = 2;
   localparam int UES_ERR_DFN8 = 3;
   localparam int UES_ERR_TURN = 4;
   localparam int UES_ERR_DMA = 5;
   localparam int UES_ERR_BMX = 6;
   localparam int UES_ERR_STUFF = 7;
   localparam int UES_CON_ENABLE = 0;
   localparam int UES_CON_REWIND = 1;
   localparam int UES_CON_RESUME = 2;
   localparam int UES_CON_HOST = 3;
   localparam int UES_CON_BUSRST = 4;
   localparam int UES_CON_PACKET_PROCESSING_DISABLE = 5;
   localparam int UES_CON_SE0 = 6;
   localparam int UES_CON_LIVE_J_STATE = 7;
   localparam int UES_INT_TRN = 0;
   localparam int UES_INT_ERR = 1;
   localparam logic [7:0] UES_ENABLES_RESET = 8'h00;
   localparam int UES_FIFO_DEPTH = 4;
   localparam int UES_TURN_BIT_TIMES = 16;
   localparam int UES_BIT_TICK_CYCLES = 1;
   localparam int UES_LS_EOP_CYCLES = 4;
   localparam logic [1:0] UES_RESP_OKAY = 2'h0;
   localparam logic [1:0] UES_RESP_SLVERR = 2'h2;
   typedef struct packed
   {
      logic [3:0] endpoint;
      logic tx;
      logic odd;
   } ues_status_t;
   typedef struct packed
   {
      logic pid_fail;
      logic token_crc_fail;
      logic data_crc_fail;
      logic partial_byte;
      logic stuff_fail;
      logic bus_matrix_fail;
      logic dma_late;
      logic dma_truncate;
   } ues_err_evt_t;
endpackage : ues_pkg

// ### rtl/ues_core.sv
`timescale 1ns/1ps
`default_nettype none
module ues_core
   import ues_pkg::*;
#(
   parameter int FIFO_DEPTH = UES_FIFO_DEPTH
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic line_j_state,
   input wire logic line_se0,
   input wire ues_err_evt_t err_evt,
   input wire logic frame_count_zero,
   input wire logic link_active,
   input wire logic eop_seen,
   input wire logic bit_tick,
   input wire logic awaiting_response,
   input wire logic response_seen,
   input wire logic setup_received,
   input wire logic token_start,
   input wire logic token_done,
   input wire logic xfer_done,
   input wire ues_status_t xfer_info,
   output logic combined_usb_interrupt,
   output logic processing_paused,
   output logic bus_reset_drive,
   output logic resume_drive,
   output logic ls_eop_drive,
   output logic host_logic_reset,
   output logic buffer_pointer_rewind,
   output logic module_enable,
   output logic frame_start_enable,
   output logic host_mode
);
   localparam int PW = $clog2(FIFO_DEPTH);
   logic [1:0] j_sync_reg;
   logic [1:0] se0_sync_reg;
   logic [7:0] err_flags_reg;
   logic [7:0] err_enables_reg;
   logic [7:0] err_set;
   logic [1:0] int_en_reg;
   logic transfer_complete_flag_reg;
   logic [7:0] control_reg;
   logic token_busy_reg;
   logic [4:0] idle_cnt_reg;
   logic idle_run_reg;
   logic [7:0] eop_cnt_reg;
   ues_status_t fifo_mem [FIFO_DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] count_reg;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_fire;
   logic pop;
   logic push;
   logic [7:0] wbyte;

   // pins are asynchronous to aclk
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         j_sync_reg <= 2'h0;
         se0_sync_reg <= 2'h0;
      end
      else
      begin
         j_sync_reg <= {j_sync_reg[0], line_j_state};
         se0_sync_reg <= {se0_sync_reg[0], line_se0};
      end
   end

   // axi write channel: address and data taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= UES_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_reg <= UES_OFF_INT_CTRL && aw_addr_reg[1:0] == 2'h0) ?
               UES_RESP_OKAY : UES_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
   assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   // only the low byte holds register bits, except the interrupt-control flag at bit 8
   assign wbyte = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;

   function automatic logic wr_to(input logic [7:0] off);
      wr_to = wr_fire && aw_addr_reg == off && w_strb_reg[0];
   endfunction : wr_to

   // error sources, mode-steered on the shared bit 1
   always_comb
   begin
      err_set = 8'h00;
      err_set[UES_ERR_PID] = err_evt.pid_fail;
      err_set[UES_ERR_CRC5_EOF] = control_reg[UES_CON_HOST] ?
         (frame_count_zero && link_active) : err_evt.token_crc_fail;
      err_set[UES_ERR_CRC16] = err_evt.data_crc_fail;
      err_set[UES_ERR_DFN8] = err_evt.partial_byte;
      err_set[UES_ERR_TURN] = idle_run_reg && bit_tick && idle_cnt_reg == 5'(UES_TURN_BIT_TIMES);
      err_set[UES_ERR_DMA] = err_evt.dma_late || err_evt.dma_truncate;
      err_set[UES_ERR_BMX] = err_evt.bus_matrix_fail;
      err_set[UES_ERR_STUFF] = err_evt.stuff_fail;
   end

   // idle counter from eop; counts bit times while a response is awaited
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         idle_cnt_reg <= 5'h00;
         idle_run_reg <= 1'b0;
      end
      else if (eop_seen && awaiting_response)
      begin
         idle_cnt_reg <= 5'h00;
         idle_run_reg <= 1'b1;
      end
      else if (response_seen || !awaiting_response)
         idle_run_reg <= 1'b0;
      else if (idle_run_reg && bit_tick)
      begin
         if (idle_cnt_reg == 5'(UES_TURN_BIT_TIMES))
            idle_run_reg <= 1'b0;
         idle_cnt_reg <= idle_cnt_reg + 5'h01;
      end
   end

   // set wins over the write-one clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         err_flags_reg <= 8'h00;
      else if (wr_to(UES_OFF_ERR_FLAGS))
         err_flags_reg <= (err_flags_reg & ~wbyte) | err_set;
      else
         err_flags_reg <= err_flags_reg | err_set;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         err_enables_reg <= UES_ENABLES_RESET;
      else if (wr_to(UES_OFF_ERR_ENABLES))
         err_enables_reg <= wbyte;
   end

   // interrupt-control: bit 0 transfer enable, bit 1 general error enable; flag at bit 8
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         int_en_reg <= 2'h0;
      else if (wr_to(UES_OFF_INT_CTRL))
         int_en_reg <= wbyte[1:0];
   end

   assign push = xfer_done && count_reg != (PW+1)'(FIFO_DEPTH);
   // popping clears the flag; it re-arms next cycle if entries remain
   assign pop = transfer_complete_flag_reg && wr_fire && aw_addr_reg == UES_OFF_INT_CTRL &&
      w_strb_reg[1] && w_data_reg[8];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + PW'(1);
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + PW'(1);
         count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (push)
         fifo_mem[wr_ptr_reg] <= xfer_info;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         transfer_complete_flag_reg <= 1'b0;
      else if (pop)
         transfer_complete_flag_reg <= 1'b0;
      else
         transfer_complete_flag_reg <= count_reg != '0;
   end

   // control bits 5..0; bit 5 is pause in device mode, read as busy in host
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         control_reg <= 8'h00;
      else
      begin
         if (wr_to(UES_OFF_CONTROL))
         begin
            control_reg[5:0] <= wbyte[5:0]; // bit 1 stands one cycle only: self-clearing strobe
         end
         else
            control_reg[UES_CON_REWIND] <= 1'b0;
         if (setup_received && !control_reg[UES_CON_HOST])
            control_reg[UES_CON_PACKET_PROCESSING_DISABLE] <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         token_busy_reg <= 1'b0;
      else if (host_logic_reset || !control_reg[UES_CON_HOST])
         token_busy_reg <= 1'b0;
      else if (token_start)
         token_busy_reg <= 1'b1;
      else if (token_done)
         token_busy_reg <= 1'b0;
   end

   // low-speed eop stretch after resume is driven in host mode only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         eop_cnt_reg <= 8'h00;
      else if (host_logic_reset)
         eop_cnt_reg <= 8'h00;
      else if (control_reg[UES_CON_HOST] && resume_drive && !control_reg[UES_CON_RESUME])
         eop_cnt_reg <= 8'(UES_LS_EOP_CYCLES);
      else if (eop_cnt_reg != 8'h00)
         eop_cnt_reg <= eop_cnt_reg - 8'h01;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         combined_usb_interrupt <= 1'b0;
         processing_paused <= 1'b0;
         bus_reset_drive <= 1'b0;
         resume_drive <= 1'b0;
         ls_eop_drive <= 1'b0;
         host_logic_reset <= 1'b0;
         buffer_pointer_rewind <= 1'b0;
         module_enable <= 1'b0;
         frame_start_enable <= 1'b0;
         host_mode <= 1'b0;
      end
      else
      begin
         combined_usb_interrupt <= (int_en_reg[UES_INT_ERR] && |(err_flags_reg & err_enables_reg)) ||
            (int_en_reg[UES_INT_TRN] && transfer_complete_flag_reg);
         processing_paused <= !control_reg[UES_CON_HOST] && control_reg[UES_CON_PACKET_PROCESSING_DISABLE];
         bus_reset_drive <= control_reg[UES_CON_HOST] && control_reg[UES_CON_BUSRST];
         resume_drive <= control_reg[UES_CON_RESUME];
         ls_eop_drive <= eop_cnt_reg != 8'h00;
         host_logic_reset <= host_mode != control_reg[UES_CON_HOST];
         buffer_pointer_rewind <= control_reg[UES_CON_REWIND];
         module_enable <= !control_reg[UES_CON_HOST] && control_reg[UES_CON_ENABLE];
         frame_start_enable <= control_reg[UES_CON_HOST] && control_reg[UES_CON_ENABLE];
         host_mode <= control_reg[UES_CON_HOST];
      end
   end

   // read channel, one cycle latency; upper 23 bits always zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= UES_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= UES_RESP_OKAY;
         unique case (s_axi_araddr)
            UES_OFF_ERR_FLAGS: s_axi_rdata <= {24'h0, err_flags_reg};
            UES_OFF_ERR_ENABLES: s_axi_rdata <= {24'h0, err_enables_reg};
            UES_OFF_XFER_STATUS: s_axi_rdata <= transfer_complete_flag_reg ?
               {24'h0, fifo_mem[rd_ptr_reg], 2'h0} : 32'h0;
            UES_OFF_CONTROL: s_axi_rdata <= {24'h0, j_sync_reg[1], se0_sync_reg[1],
               control_reg[UES_CON_HOST] ? token_busy_reg : control_reg[UES_CON_PACKET_PROCESSING_DISABLE],
               control_reg[4:2], 1'b0, control_reg[0]};
            UES_OFF_INT_CTRL: s_axi_rdata <= {23'h0, transfer_complete_flag_reg, 6'h0, int_en_reg};
            default:
            begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= UES_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
   assign s_axi_arready = !s_axi_rvalid;
endmodule : ues_core
`default_nettype wire

// ### verif/ues_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module ues_core_props
   import ues_pkg::*;
#(
   parameter int FIFO_DEPTH = UES_FIFO_DEPTH
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic setup_received,
   input wire logic processing_paused,
   input wire logic bus_reset_drive,
   input wire logic resume_drive,
   input wire logic ls_eop_drive,
   input wire logic host_logic_reset,
   input wire logic buffer_pointer_rewind,
   input wire logic module_enable,
   input wire logic frame_start_enable,
   input wire logic host_mode
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0)
      else $error("read data above bit 8 not zero");
   a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == UES_RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   a_rewind_pulse: assert property (buffer_pointer_rewind |=> !buffer_pointer_rewind)
      else $error("rewind strobe longer than one cycle");
   a_host_reset: assert property ($changed(host_mode) |-> $past(host_logic_reset) or ##[0:1] host_logic_reset)
      else $error("host enable change without host reset");
   a_lseop_len: assert property ($rose(ls_eop_drive) |-> ls_eop_drive [*4] ##1 !ls_eop_drive)
      else $error("low speed eop length wrong");
   a_lseop_cause: assert property ($fell(resume_drive) && host_mode |-> ##[0:1] ls_eop_drive)
      else $error("resume end without low speed eop");
   a_busrst_host: assert property (bus_reset_drive |-> host_mode)
      else $error("bus reset driven outside host mode");
   a_bit0_mode: assert property (frame_start_enable |-> host_mode && !module_enable)
      else $error("frame start enable outside host mode");
   a_setup_pause: assert property (setup_received && !host_mode |-> ##[1:2] processing_paused)
      else $error("setup did not pause processing");
endmodule : ues_core_props
bind ues_core ues_core_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.*);
`default_nettype wire

// ### verif/ues_cable_model.sv
`timescale 1ns/1ps
`default_nettype none
module ues_cable_model
   import ues_pkg::*;
(
   input wire logic aclk,
   output logic line_j_state,
   output logic line_se0,
   output ues_err_evt_t err_evt,
   output logic frame_count_zero,
   output logic link_active,
   output logic eop_seen,
   output logic bit_tick,
   output logic awaiting_response,
   output logic response_seen,
   output logic setup_received,
   output logic token_start,
   output logic token_done,
   output logic xfer_done,
   output ues_status_t xfer_info
);
   logic [7:0] ev_reg;
   assign setup_received = ev_reg[0];
   assign token_start = ev_reg[1];
   assign token_done = ev_reg[2];
   assign frame_count_zero = ev_reg[3];
   assign link_active = ev_reg[3];
   assign eop_seen = ev_reg[4];
   assign bit_tick = ev_reg[5];
   assign xfer_done = ev_reg[6];
   assign response_seen = ev_reg[7];
   initial
   begin
      ev_reg = 8'h00;
      err_evt = '0;
      xfer_info = '0;
      awaiting_response = 1'b0;
      line_j_state = 1'b0;
      line_se0 = 1'b0;
   end
   task automatic pulse(input int k);
      @(posedge aclk);
      ev_reg <= 8'h01 << k;
      @(posedge aclk);
      ev_reg <= 8'h00;
   endtask : pulse
   task automatic err(input ues_err_evt_t e);
      @(posedge aclk);
      err_evt <= e;
      @(posedge aclk);
      err_evt <= '0;
   endtask : err
   // stale info inverted so it is never mistaken for a fresh entry
   task automatic xfer(input ues_status_t s);
      @(posedge aclk);
      xfer_info <= s;
      ev_reg <= 8'h40;
      @(posedge aclk);
      ev_reg <= 8'h00;
      xfer_info <= ~s;
   endtask : xfer
   task automatic turn(input int n);
      @(posedge aclk);
      awaiting_response <= 1'b1;
      pulse(4);
      repeat (n) pulse(5);
      awaiting_response <= 1'b0;
   endtask : turn
   task automatic lines(input logic j, input logic z);
      @(posedge aclk);
      line_j_state <= j;
      line_se0 <= z;
   endtask : lines
endmodule : ues_cable_model
`default_nettype wire

// ### verif/test_usb_error_status_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_usb_error_status_control
   import ues_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic line_j_state, line_se0, frame_count_zero, link_active, eop_seen, bit_tick, awaiting_response;
   logic response_seen, setup_received, token_start, token_done, xfer_done;
   ues_err_evt_t err_evt;
   ues_status_t xfer_info;
   logic combined_usb_interrupt, processing_paused, bus_reset_drive, resume_drive, ls_eop_drive;
   logic host_logic_reset, buffer_pointer_rewind, module_enable, frame_start_enable, host_mode;
   integer seed;
   int err_count, n_compared, n_rew, n_eop, n_hrst;
   logic [31:0] rd;
   logic [1:0] rs;
   logic [7:0] en;
   logic ge;
   ues_status_t s;
   ues_status_t q[$];
   ues_core dut (.*);
   ues_cable_model cab (.*);
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      n_rew += (buffer_pointer_rewind === 1'b1);
      n_eop += (ls_eop_drive === 1'b1);
      n_hrst += (host_logic_reset === 1'b1);
   end
   function automatic int flag_pos(input int k);
      case (k)
         7: return UES_ERR_PID;
         6: return UES_ERR_CRC5_EOF;
         5: return UES_ERR_CRC16;
         4: return UES_ERR_DFN8;
         3: return UES_ERR_STUFF;
         2: return UES_ERR_BMX;
         default: return UES_ERR_DMA;
      endcase
   endfunction : flag_pos
   function automatic logic [31:0] stat_word(input ues_status_t v);
      return {24'h0, v.endpoint, v.tx, v.odd, 2'b00};
   endfunction : stat_word
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   // generous bound: the whole sequence needs under a thousand cycles
   initial
   begin
      repeat (30000) @(posedge aclk);
      err_count++;
      give_verdict();
   end
   initial
   begin
      seed = 38;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      aresetn = 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a < 5; a++)
      begin
         axi_rd(8'(a * 4));
         `CHK(rd, 32'h0);
      end
      axi_rd(8'h14);
      `CHK(rd, 32'h0);
      `CHK(rs, UES_RESP_SLVERR);
      axi_wr(8'h40, 32'hFF);
      `CHK(rs, UES_RESP_SLVERR);
      $display("reset and map test done");
      for (int k = 0; k < 8; k++)
      begin
         en = 8'($random(seed));
         ge = 1'($random(seed));
         axi_wr(UES_OFF_ERR_ENABLES, {24'h0, en});
         axi_wr(UES_OFF_INT_CTRL, {30'h0, ge, 1'b0});
         cab.err(8'h01 << k);
         axi_rd(UES_OFF_ERR_FLAGS);
         `CHK(rd, 32'h1 << flag_pos(k));
         `CHK(combined_usb_interrupt, en[flag_pos(k)] & ge);
         axi_wr(UES_OFF_ERR_FLAGS, 32'h0);
         axi_rd(UES_OFF_ERR_FLAGS);
         `CHK(rd, 32'h1 << flag_pos(k));
         axi_rd(UES_OFF_ERR_ENABLES);
         `CHK(rd, {24'h0, en});
         axi_wr(UES_OFF_ERR_FLAGS, 32'h1 << flag_pos(k));
         axi_rd(UES_OFF_ERR_FLAGS);
         `CHK(rd, 32'h0);
         `CHK(combined_usb_interrupt, 1'b0);
      end
      cab.turn(UES_TURN_BIT_TIMES);
      axi_rd(UES_OFF_ERR_FLAGS);
      `CHK(rd, 32'h0);
      cab.turn(UES_TURN_BIT_TIMES + 1);
      axi_rd(UES_OFF_ERR_FLAGS);
      `CHK(rd, 32'h1 << UES_ERR_TURN);
      axi_wr(UES_OFF_ERR_FLAGS, 32'hFF);
      $display("error flag test done");
      axi_wr(UES_OFF_CONTROL, 32'h01);
      cab.pulse(0);
      axi_rd(UES_OFF_CONTROL);
      `CHK(rd, 32'h21);
      `CHK({processing_paused, module_enable, frame_start_enable}, 3'b110);
      axi_wr(UES_OFF_CONTROL, 32'h03);
      axi_rd(UES_OFF_CONTROL);
      `CHK(rd, 32'h01);
      `CHK(processing_paused, 1'b0);
      `CHK(n_rew, 1);
      cab.lines(1'b1, 1'b0);
      repeat (4) @(posedge aclk);
      axi_rd(UES_OFF_CONTROL);
      `CHK(rd, 32'h81);
      cab.lines(1'b0, 1'b1);
      repeat (4) @(posedge aclk);
      axi_rd(UES_OFF_CONTROL);
      `CHK(rd, 32'h41);
      cab.lines(1'b0, 1'b0);
      $display("device control test done");
      axi_wr(UES_OFF_CONTROL, 32'h09);
      cab.pulse(3);
      axi_rd(UES_OFF_ERR_FLAGS);
      `CHK(rd, 32'h1 << UES_ERR_CRC5_EOF);
      `CHK({host_mode, frame_start_enable, module_enable}, 3'b110);
      `CHK(n_hrst, 1);
      axi_wr(UES_OFF_ERR_FLAGS, 32'h02);
      cab.err(8'h40);
      axi_rd(UES_OFF_ERR_FLAGS);
      `CHK(rd, 32'h0);
      cab.pulse(1);
      axi_rd(UES_OFF_CONTROL);
      `CHK(rd, 32'h29);
      cab.pulse(2);
      axi_rd(UES_OFF_CONTROL);
      `CHK(rd, 32'h09);
      axi_wr(UES_OFF_CONTROL, 32'h19);
      @(posedge aclk);
      `CHK(bus_reset_drive, 1'b1);
      axi_wr(UES_OFF_CONTROL, 32'h0D);
      @(posedge aclk);
      `CHK({bus_reset_drive, resume_drive}, 2'b01);
      // resume held far shorter than wake-up needs, to keep the run short
      axi_wr(UES_OFF_CONTROL, 32'h09);
      repeat (8) @(posedge aclk);
      `CHK(n_eop, UES_LS_EOP_CYCLES);
      axi_wr(UES_OFF_CONTROL, 32'h01);
      axi_rd(UES_OFF_CONTROL);
      `CHK(host_mode, 1'b0);
      `CHK(n_hrst, 2);
      $display("host control test done");
      axi_wr(UES_OFF_INT_CTRL, 32'h1);
      for (int i = 0; i <= UES_FIFO_DEPTH; i++)
      begin
         s = (i == 0) ? 6'h3F : 6'($random(seed));
         cab.xfer(s);
         if (q.size() < UES_FIFO_DEPTH) q.push_back(s);
      end
      for (int i = 0; i < UES_FIFO_DEPTH; i++)
      begin
         axi_rd(UES_OFF_INT_CTRL);
         `CHK(rd, 32'h101);
         `CHK(combined_usb_interrupt, 1'b1);
         axi_rd(UES_OFF_XFER_STATUS);
         `CHK(rd, stat_word(q[i]));
         axi_wr(UES_OFF_INT_CTRL, 32'h101);
      end
      axi_rd(UES_OFF_INT_CTRL);
      `CHK(rd, 32'h1);
      `CHK(combined_usb_interrupt, 1'b0);
      $display("status fifo test done");
      give_verdict();
   end
endmodule : test_usb_error_status_control
`undef CHK
`default_nettype wire
